/* rtl/sqrc_ctrl.sv */
`timescale 1ns/1ps
module sqrc_ctrl
    import sqrc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [11:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic [7:0] multiplexed_counter_pulse,
    input wire logic ac_sync_pulse,
    input wire logic [1:0] ext_arm_pin,
    input wire logic [1:0] ext_trig_pin,
    input wire logic [1:0] seq_done,
    output logic [1:0] seq_start,
    output logic [1:0] seq_playback_reset,
    output logic [1:0] seq_running_flag,
    output logic [1:0] seq_enabled_flag,
    output logic [1:0] seq_single_mode,
    output logic [1:0] seq_recycle_mode,
    output logic [3:0] seq_shared_sw_mask,
    output logic [3:0] seq_shared_sw_enable
);
    sqrc_cfg_t cfg [SQRC_NUM_SEQ];
    sqrc_cfg_t next_cfg [SQRC_NUM_SEQ];
    logic [3:0] next_mask;
    logic [3:0] next_swena;
    logic [1:0] swt_p, next_swt_p;
    logic [1:0] res_p, next_res_p;
    logic [1:0] dis_p, next_dis_p;
    logic [1:0] arm_p, next_arm_p;
    logic [31:0] next_rdata;
    logic [1:0] hit;
    logic [1:0] ext_q;
    logic [1:0] trig;

    // picks the trigger source for one sequencer; codes without a source give zero
    function automatic logic sel_trig(input logic [4:0] sel, input logic [7:0] mxc, input logic ac,
                                      input logic [1:0] swt, input logic [1:0] ext);
        logic t;
        t = 1'b0;
        case (sel)
            SQRC_TSEL_AC: t = ac;
            SQRC_TSEL_SWT0: t = swt[0];
            SQRC_TSEL_SWT1: t = swt[1];
            SQRC_TSEL_IMMED: t = 1'b1;
            SQRC_TSEL_EXT0: t = ext[0];
            SQRC_TSEL_EXT1: t = ext[1];
            default: t = (sel[4:3] == 2'b00) ? mxc[sel[2:0]] : 1'b0;
        endcase
        return t;
    endfunction

    assign hit[0] = (addr == SQRC_OFF_SEQ0);
    assign hit[1] = (addr == SQRC_OFF_SEQ1);

    // register file: config, shared fields, strobe pulses and read data
    always_comb begin
        next_mask = seq_shared_sw_mask;
        next_swena = seq_shared_sw_enable;
        next_rdata = 32'h0;
        for (int i = 0; i < SQRC_NUM_SEQ; i++) begin
            next_cfg[i] = cfg[i];
            next_swt_p[i] = 1'b0;
            next_res_p[i] = 1'b0;
            next_dis_p[i] = 1'b0;
            next_arm_p[i] = 1'b0;
            if (wr && hit[i]) begin
                next_cfg[i].ext_trig_allow = wdata[SQRC_B_XTR];
                next_cfg[i].ext_arm_allow = wdata[SQRC_B_XEN];
                next_cfg[i].single = wdata[SQRC_B_SNG];
                next_cfg[i].recycle = wdata[SQRC_B_REC];
                next_cfg[i].tsel = wdata[SQRC_B_TSEL_LO +: 5];
                next_swt_p[i] = wdata[SQRC_B_SWT];
                next_res_p[i] = wdata[SQRC_B_RES];
                next_dis_p[i] = wdata[SQRC_B_DIS];
                next_arm_p[i] = wdata[SQRC_B_EN];
                // either word reaches the same shared storage
                next_mask = wdata[SQRC_B_MASK_LO +: 4];
                next_swena = wdata[SQRC_B_SWENA_LO +: 4];
            end
            if (rd && hit[i]) begin
                // strobe positions stay zero on read
                next_rdata[SQRC_B_RUN] = seq_running_flag[i];
                next_rdata[SQRC_B_ENA] = seq_enabled_flag[i];
                next_rdata[SQRC_B_XTR] = cfg[i].ext_trig_allow;
                next_rdata[SQRC_B_XEN] = cfg[i].ext_arm_allow;
                next_rdata[SQRC_B_SNG] = cfg[i].single;
                next_rdata[SQRC_B_REC] = cfg[i].recycle;
                next_rdata[SQRC_B_MASK_LO +: 4] = seq_shared_sw_mask;
                next_rdata[SQRC_B_SWENA_LO +: 4] = seq_shared_sw_enable;
                next_rdata[SQRC_B_TSEL_LO +: 5] = cfg[i].tsel;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            for (int i = 0; i < SQRC_NUM_SEQ; i++) begin
                cfg[i] <= SQRC_CFG_RST;
            end
            seq_shared_sw_mask <= SQRC_MASK_RST;
            seq_shared_sw_enable <= SQRC_SWENA_RST;
            swt_p <= 2'h0;
            res_p <= 2'h0;
            dis_p <= 2'h0;
            arm_p <= 2'h0;
            rdata <= 32'h0;
        end else begin
            for (int i = 0; i < SQRC_NUM_SEQ; i++) begin
                cfg[i] <= next_cfg[i];
            end
            seq_shared_sw_mask <= next_mask;
            seq_shared_sw_enable <= next_swena;
            swt_p <= next_swt_p;
            res_p <= next_res_p;
            dis_p <= next_dis_p;
            arm_p <= next_arm_p;
            rdata <= next_rdata;
        end
    end

    generate
        for (genvar i = 0; i < SQRC_NUM_SEQ; i++) begin : g_seq
            logic [2:0] arm_sync, trig_sync;
            logic arm_lvl, trig_lvl, next_arm_lvl, next_trig_lvl;
            logic arm_edge, trig_edge;
            logic arm_set, dis_eff;
            sqrc_state_t state, next_state;
            logic next_start, next_preset;

            // pin filter: a level counts only once stages two and three agree
            always_comb begin
                next_arm_lvl = (arm_sync[1] == arm_sync[2]) ? arm_sync[2] : arm_lvl;
                next_trig_lvl = (trig_sync[1] == trig_sync[2]) ? trig_sync[2] : trig_lvl;
            end

            always_ff @(posedge mclk) begin
                if (!rst_b) begin
                    arm_sync <= 3'h0;
                    trig_sync <= 3'h0;
                    arm_lvl <= 1'b0;
                    trig_lvl <= 1'b0;
                    arm_edge <= 1'b0;
                    trig_edge <= 1'b0;
                end else begin
                    arm_sync <= {arm_sync[1:0], ext_arm_pin[i]};
                    trig_sync <= {trig_sync[1:0], ext_trig_pin[i]};
                    arm_lvl <= next_arm_lvl;
                    trig_lvl <= next_trig_lvl;
                    arm_edge <= next_arm_lvl & ~arm_lvl;
                    trig_edge <= next_trig_lvl & ~trig_lvl;
                end
            end

            // external events count only while their allow bits are set
            assign ext_q[i] = trig_edge & cfg[i].ext_trig_allow;
            assign arm_set = (arm_p[i] & ~dis_p[i]) | (arm_edge & cfg[i].ext_arm_allow);
            // an external arm in the same cycle beats a disable strobe
            assign dis_eff = dis_p[i] & ~arm_set;
            assign trig[i] = sel_trig(cfg[i].tsel, multiplexed_counter_pulse, ac_sync_pulse, swt_p, ext_q);

            // arm, start, end-of-sequence handling
            always_comb begin
                next_state = state;
                next_start = 1'b0;
                next_preset = res_p[i];
                unique case (state)
                    SQRC_IDLE: begin
                        if (arm_set) begin
                            next_state = SQRC_ARMED;
                        end
                    end
                    SQRC_ARMED: begin
                        if (dis_eff) begin
                            next_state = SQRC_IDLE;
                        end else if (trig[i]) begin
                            next_state = SQRC_RUN;
                            next_start = 1'b1;
                        end
                    end
                    SQRC_RUN: begin
                        if (dis_eff) begin
                            next_state = SQRC_IDLE;
                        end else if (res_p[i]) begin
                            next_state = SQRC_ARMED;
                        end else if (seq_done[i]) begin
                            if (cfg[i].recycle) begin
                                next_start = 1'b1;
                            end else if (cfg[i].single && !arm_set) begin
                                next_state = SQRC_IDLE;
                            end else begin
                                next_state = SQRC_ARMED;
                            end
                        end
                    end
                    default: next_state = SQRC_IDLE;
                endcase
            end

            always_ff @(posedge mclk) begin
                if (!rst_b) begin
                    state <= SQRC_IDLE;
                    seq_start[i] <= 1'b0;
                    seq_playback_reset[i] <= 1'b0;
                end else begin
                    state <= next_state;
                    seq_start[i] <= next_start;
                    seq_playback_reset[i] <= next_preset;
                end
            end

            assign seq_running_flag[i] = (state == SQRC_RUN);
            assign seq_enabled_flag[i] = (state != SQRC_IDLE);
            assign seq_single_mode[i] = cfg[i].single;
            assign seq_recycle_mode[i] = cfg[i].recycle;

            AST_RUN_NEEDS_ENA: assert property (@(posedge mclk) disable iff (!rst_b)
                seq_running_flag[i] |-> seq_enabled_flag[i]) else $error("running while not enabled");
            AST_START_RUNS: assert property (@(posedge mclk) disable iff (!rst_b)
                seq_start[i] |-> seq_running_flag[i]) else $error("start without running flag");
            AST_SWT_PULSE: assert property (@(posedge mclk) disable iff (!rst_b)
                (wr && hit[i] && wdata[SQRC_B_SWT]) |=> swt_p[i]) else $error("software trigger lost");
            AST_SINGLE_END: assert property (@(posedge mclk) disable iff (!rst_b)
                (state == SQRC_RUN && seq_done[i] && cfg[i].single && !cfg[i].recycle && !res_p[i]
                 && !dis_p[i] && !arm_set) |=> !seq_enabled_flag[i]) else $error("single mode kept armed");
            AST_RECYCLE_END: assert property (@(posedge mclk) disable iff (!rst_b)
                (state == SQRC_RUN && seq_done[i] && cfg[i].recycle && !res_p[i] && !dis_eff)
                |=> seq_start[i] && seq_running_flag[i]) else $error("recycle did not restart");
            AST_RESET_STROBE: assert property (@(posedge mclk) disable iff (!rst_b)
                (wr && hit[i] && wdata[SQRC_B_RES] && !wdata[SQRC_B_DIS]) ##1 (state == SQRC_RUN)
                |=> seq_playback_reset[i] && !seq_running_flag[i]) else $error("reset strobe ignored");
            AST_DISABLE: assert property (@(posedge mclk) disable iff (!rst_b)
                dis_eff |=> !seq_enabled_flag[i]) else $error("disable did not clear enabled");
            AST_ARM_WRITE: assert property (@(posedge mclk) disable iff (!rst_b)
                (wr && hit[i] && wdata[SQRC_B_EN] && !wdata[SQRC_B_DIS]) |=> ##1 seq_enabled_flag[i])
                else $error("arm write did not enable");
            AST_EXT_ARM: assert property (@(posedge mclk) disable iff (!rst_b)
                (state == SQRC_IDLE && !arm_p[i] && !(arm_edge && cfg[i].ext_arm_allow))
                |=> !seq_enabled_flag[i]) else $error("armed without cause");
            AST_EXT_TRIG_GATE: assert property (@(posedge mclk) disable iff (!rst_b)
                !cfg[i].ext_trig_allow |-> !ext_q[i]) else $error("external trigger passed while barred");
            AST_MXC_ROUTE: assert property (@(posedge mclk) disable iff (!rst_b)
                (cfg[i].tsel < 5'h08) |-> trig[i] == multiplexed_counter_pulse[cfg[i].tsel[2:0]])
                else $error("counter route wrong");
            AST_AC_ROUTE: assert property (@(posedge mclk) disable iff (!rst_b)
                (cfg[i].tsel == SQRC_TSEL_AC) |-> trig[i] == ac_sync_pulse) else $error("ac route wrong");
            AST_SWT_ROUTE: assert property (@(posedge mclk) disable iff (!rst_b)
                (cfg[i].tsel == SQRC_TSEL_SWT1) |-> trig[i] == swt_p[1]) else $error("software route wrong");
            AST_IMMEDIATE: assert property (@(posedge mclk) disable iff (!rst_b)
                (state == SQRC_ARMED && cfg[i].tsel == SQRC_TSEL_IMMED && !dis_eff) |=> seq_start[i])
                else $error("immediate start missing");
            AST_EXT_ROUTE: assert property (@(posedge mclk) disable iff (!rst_b)
                (cfg[i].tsel == SQRC_TSEL_EXT0) |-> trig[i] == ext_q[0]) else $error("external route wrong");
            AST_EXT1_ROUTE: assert property (@(posedge mclk) disable iff (!rst_b)
                (cfg[i].tsel == SQRC_TSEL_EXT1) |-> trig[i] == ext_q[1]) else $error("external one route wrong");
            AST_SWT0_ROUTE: assert property (@(posedge mclk) disable iff (!rst_b)
                (cfg[i].tsel == SQRC_TSEL_SWT0) |-> trig[i] == swt_p[0]) else $error("software zero route wrong");
            // the playback reset pulse must trace back to a reset strobe, never appear on its own
            AST_PB_RESET_CAUSE: assert property (@(posedge mclk) disable iff (!rst_b)
                seq_playback_reset[i] |-> $past(res_p[i])) else $error("playback reset without strobe");
            // a disable write with no external arm allowed must leave the sequencer idle
            AST_DISABLE_WRITE: assert property (@(posedge mclk) disable iff (!rst_b)
                (wr && hit[i] && wdata[SQRC_B_DIS] && !wdata[SQRC_B_XEN] && !cfg[i].ext_arm_allow)
                |=> ##1 !seq_enabled_flag[i]) else $error("disable write left sequencer enabled");
            AST_OFF_NO_START: assert property (@(posedge mclk) disable iff (!rst_b)
                (state == SQRC_ARMED && cfg[i].tsel == SQRC_TSEL_OFF) |=> !seq_start[i])
                else $error("start while triggering off");
            AST_UNASSIGNED: assert property (@(posedge mclk) disable iff (!rst_b)
                (cfg[i].tsel inside {[5'h08:5'h0f], [5'h14:5'h17], [5'h1a:5'h1f]}) |-> !trig[i])
                else $error("unassigned select triggered");

            COV_IMMED_RUN: cover property (@(posedge mclk) disable iff (!rst_b)
                arm_p[i] ##1 (state == SQRC_ARMED) ##1 seq_start[i]);
            COV_RECYCLE: cover property (@(posedge mclk) disable iff (!rst_b)
                (seq_done[i] && cfg[i].recycle && seq_running_flag[i]) ##1 seq_start[i]);
            COV_EXT_ARM: cover property (@(posedge mclk) disable iff (!rst_b)
                arm_edge && cfg[i].ext_arm_allow && state == SQRC_IDLE);
        end
    endgenerate

    AST_SHARED_FIELDS: assert property (@(posedge mclk) disable iff (!rst_b)
        (wr && hit[1]) |=> seq_shared_sw_mask == $past(wdata[15:12]) && seq_shared_sw_enable == $past(wdata[11:8]))
        else $error("shared mask or enable not updated");
    AST_STROBES_READ_ZERO: assert property (@(posedge mclk) disable iff (!rst_b)
        rd |=> rdata[21] == 1'b0 && rdata[18:16] == 3'h0) else $error("strobe bit read nonzero");
    AST_STROBE_ONE_CYCLE: assert property (@(posedge mclk) disable iff (!rst_b)
        (swt_p[0] && !$past(wr)) |-> 1'b0) else $error("software trigger longer than one cycle");
    // read data stands for one cycle only, so an idle bus must read back zero
    AST_RDATA_IDLE: assert property (@(posedge mclk) disable iff (!rst_b)
        !rd |=> rdata == 32'h0) else $error("read data held without read");

    // the port widths are fixed at two sequencers and eight counters
    if (SQRC_NUM_SEQ != 2 || SQRC_NUM_MXC != 8) begin : g_bad_size
        $error("sequencer or counter count does not match the port widths");
    end
    COV_CROSS_SWT: cover property (@(posedge mclk) disable iff (!rst_b)
        swt_p[0] && cfg[1].tsel == SQRC_TSEL_SWT0 && g_seq[1].state == SQRC_ARMED);
endmodule

/* rtl/sqrc_pkg.sv */
package sqrc_pkg;
    localparam int SQRC_ADDR_W = 12;
    localparam int SQRC_NUM_SEQ = 2;
    localparam int SQRC_NUM_MXC = 8;
    // byte addresses of the two control words
    localparam logic [11:0] SQRC_OFF_SEQ0 = 12'h070;
    localparam logic [11:0] SQRC_OFF_SEQ1 = 12'h074;
    // field positions inside a control word
    localparam int SQRC_B_RUN = 25;
    localparam int SQRC_B_ENA = 24;
    localparam int SQRC_B_XTR = 23;
    localparam int SQRC_B_XEN = 22;
    localparam int SQRC_B_SWT = 21;
    localparam int SQRC_B_SNG = 20;
    localparam int SQRC_B_REC = 19;
    localparam int SQRC_B_RES = 18;
    localparam int SQRC_B_DIS = 17;
    localparam int SQRC_B_EN = 16;
    localparam int SQRC_B_MASK_LO = 12;
    localparam int SQRC_B_SWENA_LO = 8;
    localparam int SQRC_B_TSEL_LO = 0;
    // trigger select codes
    localparam logic [4:0] SQRC_TSEL_AC = 5'h10;
    localparam logic [4:0] SQRC_TSEL_SWT0 = 5'h11;
    localparam logic [4:0] SQRC_TSEL_SWT1 = 5'h12;
    localparam logic [4:0] SQRC_TSEL_IMMED = 5'h13;
    localparam logic [4:0] SQRC_TSEL_EXT0 = 5'h18;
    localparam logic [4:0] SQRC_TSEL_EXT1 = 5'h19;
    localparam logic [4:0] SQRC_TSEL_OFF = 5'h1f;

    typedef struct packed {
        logic ext_trig_allow;
        logic ext_arm_allow;
        logic single;
        logic recycle;
        logic [4:0] tsel;
    } sqrc_cfg_t;

    localparam sqrc_cfg_t SQRC_CFG_RST = '{1'b0, 1'b0, 1'b0, 1'b0, SQRC_TSEL_OFF};
    localparam logic [3:0] SQRC_MASK_RST = 4'h0;
    localparam logic [3:0] SQRC_SWENA_RST = 4'h0;

    // gray-coded along idle -> armed -> running
    typedef enum logic [1:0] {
        SQRC_IDLE = 2'b00,
        SQRC_ARMED = 2'b01,
        SQRC_RUN = 2'b11
    } sqrc_state_t;
endpackage

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top
    import sqrc_pkg::*;
;
    logic mclk, rst_b, wr, rd, ac;
    logic [11:0] addr;
    logic [31:0] wdata, rdata, shm, rv;
    logic [7:0] mxc;
    logic [1:0] ext_arm, ext_trig, done, start, pb_reset, running, enabled, single, recycle;
    logic [3:0] mask, swena;
    logic [31:0] cfg [2];
    logic [4:0] srcs [6] = '{5'h10, 5'h11, 5'h12, 5'h13, 5'h18, 5'h19};
    logic [4:0] spare [6] = '{5'h08, 5'h0f, 5'h14, 5'h17, 5'h1a, 5'h1e};
    int mismatches = 0;
    int n_compared = 0;
    int starts0 = 0;
    int resets0 = 0;
    localparam logic [31:0] B_EN = 32'h0001_0000;
    localparam logic [31:0] B_DIS = 32'h0002_0000;
    localparam logic [31:0] B_RES = 32'h0004_0000;
    localparam logic [31:0] B_SWT = 32'h0020_0000;

    sqrc_ctrl sqrc_ctrl_i (.mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .multiplexed_counter_pulse(mxc), .ac_sync_pulse(ac), .ext_arm_pin(ext_arm),
        .ext_trig_pin(ext_trig), .seq_done(done), .seq_start(start), .seq_playback_reset(pb_reset),
        .seq_running_flag(running), .seq_enabled_flag(enabled), .seq_single_mode(single),
        .seq_recycle_mode(recycle), .seq_shared_sw_mask(mask), .seq_shared_sw_enable(swena));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // count start and playback-reset pulses of sequencer 0 so checks see every one-cycle pulse
    always @(posedge mclk) begin
        if (start[0] === 1'b1) starts0 <= starts0 + 1;
        if (pb_reset[0] === 1'b1) resets0 <= resets0 + 1;
    end

    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // settle one ns past the edge so the pulse counters have landed
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic chk_reg(input string what, input logic [11:0] a, input logic [31:0] exp);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        rv = rdata;
        chk(what, exp, rv);
    endtask

    // the shared mask/enable travels in every write, else a write to one word clobbers it
    task automatic wr_cfg(input int s, input logic [31:0] extra);
        wr_reg(s != 0 ? SQRC_OFF_SEQ1 : SQRC_OFF_SEQ0, cfg[s] | shm | extra);
    endtask

    task automatic pulse_done;
        @(posedge mclk);
        done <= 2'b01;
        @(posedge mclk);
        done <= 2'b00;
    endtask

    // raise the one source that a select code names; ext pins held long enough for the filter
    task automatic fire(input logic [4:0] code);
        @(posedge mclk);
        if (code < 5'h08) mxc[code[2:0]] <= 1'b1;
        else if (code == SQRC_TSEL_AC) ac <= 1'b1;
        else if (code == SQRC_TSEL_EXT0 || code == SQRC_TSEL_EXT1) ext_trig[code[0]] <= 1'b1;
        @(posedge mclk);
        mxc <= 8'h00;
        ac <= 1'b0;
        if (code == SQRC_TSEL_SWT0 || code == SQRC_TSEL_SWT1) wr_cfg(code == SQRC_TSEL_SWT1, B_SWT);
        cyc(8);
        ext_trig <= 2'b00;
        cyc(6);
    endtask

    // arm sequencer 0 on a select, fire its source (or every source), expect exp starts
    task automatic run_code(input logic [4:0] code, input int exp, input logic allow);
        int s0;
        s0 = starts0;
        cfg[0] = {8'h00, allow, 18'h0, code};
        wr_cfg(0, B_EN);
        cyc(3);
        chk("enabled", 32'h1, {31'h0, enabled[0]});
        chk("early start", {31'h0, code == SQRC_TSEL_IMMED}, starts0 - s0);
        if (exp == 1 || code == SQRC_TSEL_IMMED) begin
            fire(code);
        end else begin
            for (int i = 0; i < 14; i++) fire(i < 8 ? 5'(i) : srcs[i - 8]);
        end
        chk("starts", exp, starts0 - s0);
        chk("running", exp, {31'h0, running[0]});
        wr_cfg(0, B_DIS);
        cyc(3);
        chk("disabled", 32'h0, {30'h0, running[0], enabled[0]});
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        complete_run();
    end

    initial begin
        int s0;
        rst_b = 1'b0;
        {wr, rd, ac} = 3'b000;
        addr = 12'h000;
        wdata = 32'h0;
        mxc = 8'h00;
        {ext_arm, ext_trig, done} = 6'h00;
        shm = 32'h0;
        cfg[0] = 32'h0000_001f;
        cfg[1] = 32'h0080_001f;
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        chk_reg("seq0 reset", SQRC_OFF_SEQ0, 32'h0000_001f);
        chk_reg("seq1 reset", SQRC_OFF_SEQ1, 32'h0000_001f);
        chk_reg("unmapped", 12'h078, 32'h0);
        $display("test reset values done");
        wr_cfg(1, 32'h0);
        for (int i = 0; i < 14; i++) run_code(i < 8 ? 5'(i) : srcs[i - 8], 1, 1'b1);
        for (int i = 0; i < 6; i++) run_code(spare[i], 0, 1'b1);
        run_code(SQRC_TSEL_OFF, 0, 1'b1);
        run_code(SQRC_TSEL_EXT0, 0, 1'b0);
        $display("test trigger selects done");
        // single mode with immediate start, shared fields seen through the other word
        shm = 32'h0000_a500;
        cfg[0] = {11'h0, 1'b1, 15'h0, SQRC_TSEL_IMMED};
        s0 = starts0;
        wr_cfg(0, B_EN);
        cyc(4);
        chk_reg("seq0 running", SQRC_OFF_SEQ0, cfg[0] | shm | 32'h0300_0000);
        chk_reg("shared via seq1", SQRC_OFF_SEQ1, cfg[1] | shm);
        chk("mask enable", 32'h0000_00a5, {24'h0, mask, swena});
        chk("single out", 32'h1, {31'h0, single[0]});
        pulse_done();
        cyc(3);
        chk("single stop", 32'h0, {30'h0, running[0], enabled[0]});
        chk("single starts", 32'h1, starts0 - s0);
        $display("test single mode done");
        // recycle: restart on done, then reset strobe returns to armed
        cfg[0] = {12'h0, 1'b1, 14'h0, SQRC_TSEL_SWT0};
        s0 = starts0;
        wr_cfg(0, B_EN);
        cyc(3);
        fire(SQRC_TSEL_SWT0);
        pulse_done();
        cyc(3);
        chk("recycle starts", 32'h2, starts0 - s0);
        chk("recycle run", 32'h3, {30'h0, recycle[0], running[0]});
        s0 = resets0;
        wr_cfg(0, B_RES);
        cyc(3);
        chk("pb reset", 32'h1, resets0 - s0);
        chk("after reset", 32'h1, {30'h0, running[0], enabled[0]});
        wr_cfg(0, B_DIS);
        $display("test recycle and reset done");
        // external arm honoured only with its allow bit
        for (int a = 1; a >= 0; a--) begin
            cfg[0] = {9'h0, a[0], 17'h0, SQRC_TSEL_OFF};
            wr_cfg(0, 32'h0);
            ext_arm <= 2'b01;
            cyc(12);
            chk("ext arm", a, {31'h0, enabled[0]});
            ext_arm <= 2'b00;
            wr_cfg(0, B_DIS);
            cyc(3);
        end
        $display("test external arm done");
        // sequencer 1 follows the software trigger of sequencer 0
        cfg[1] = {8'h00, 1'b1, 18'h0, SQRC_TSEL_SWT0};
        wr_cfg(1, B_EN);
        cyc(3);
        chk("seq1 armed", 32'h1, {30'h0, running[1], enabled[1]});
        fire(SQRC_TSEL_SWT0);
        chk("seq1 cross run", 32'h3, {30'h0, running[1], enabled[1]});
        chk("seq0 untouched", 32'h0, {30'h0, running[0], enabled[0]});
        chk_reg("seq1 running", SQRC_OFF_SEQ1, cfg[1] | shm | 32'h0300_0000);
        wr_cfg(1, B_DIS);
        cyc(3);
        chk("seq1 disabled", 32'h0, {30'h0, running[1], enabled[1]});
        $display("test cross trigger done");
        complete_run();
    end
endmodule
